// >>> hw/gsp_gpio_notify.sv
/*
 Pin state registers, change masking and notification packet builder for one channel.
 Assumes a synchronous AXI4-Lite master, synchronous pin inputs and a packet sink that
 takes one byte per cycle while pkt_ready is high.
*/
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps
module gsp_gpio_notify
	import gsp_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [9:0] gpio_in,
	output logic [9:0] gpio_out,
	output logic [9:0] gpio_oe,
	input wire logic [9:0] alt_sel,
	input wire logic [9:0] alt_out,
	input wire logic [9:0] alt_oe,
	input wire logic uart_overrun,
	input wire logic uart_parity_err,
	input wire logic uart_framing_err,
	input wire logic uart_break,
	input wire logic modem_ring,
	input wire logic modem_dsr,
	input wire logic modem_cd,
	output logic [7:0] pkt_data,
	output logic pkt_valid,
	output logic pkt_last,
	input wire logic pkt_ready,
	output logic irq
);
	function automatic logic [9:0] lane_merge(input logic [9:0] old, input logic [31:0] d, input logic [3:0] s);
		lane_merge = {s[1] ? d[9:8] : old[9:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	logic [9:0] dir_r, out_r, mask_r, prev_r, chg_r, snap_lvl_r, snap_chg_r;
	logic [1:0] ctrl_r;
	logic [2:0] istat_r, imask_r;
	logic [5:0] aw_idx_r;
	logic [31:0] wd_r, rdata_r;
	logic [3:0] ws_r, idx_r;
	logic aw_held_r, w_held_r, bvalid_r, bad_w_r, rvalid_r, bad_r_r;
	logic ovr_r, brk_prev_r, fmt_r, trig_r;
	logic [6:0] snap_st_r;
	logic [7:0] pkt_data_r;
	gsp_state_type state_r, state_nxt;

	wire wr_fire = aw_held_r && w_held_r && !bvalid_r;
	wire wr_ok = wr_fire && (aw_idx_r inside {GSP_IDX_DIR, GSP_IDX_SET, GSP_IDX_CLR, GSP_IDX_LEVEL,
		GSP_IDX_MASK, GSP_IDX_CTRL, GSP_IDX_IRQ_STAT, GSP_IDX_IRQ_MASK});
	wire [9:0] wbits = lane_merge(10'h000, wd_r, ws_r);
	wire [5:0] rd_idx = s_axi_araddr[7:2];
	wire rd_fire = s_axi_arvalid && !rvalid_r;
	wire [9:0] gp_out = dir_r & ~alt_sel;
	// inputs counted whatever the pin function
	wire [9:0] is_input = (alt_sel & ~alt_oe) | (~alt_sel & ~dir_r);
	wire [9:0] pin_chg = (gpio_in ^ prev_r) & is_input;
	wire brk_edge = uart_break && !brk_prev_r;
	wire chg_trig = |(pin_chg & ~mask_r);
	// break raises a packet only when enabled
	wire brk_trig = brk_edge && ctrl_r[GSP_CTRL_BRK];
	wire pkt_hs = pkt_valid && pkt_ready;
	wire [3:0] pkt_len = fmt_r ? GSP_CUS_BYTES : GSP_STD_BYTES;
	wire pkt_end = pkt_hs && pkt_last;
	wire pkt_start = (state_r == GSP_IDLE) && trig_r;
	wire [2:0] ev = {pkt_end, brk_edge, |pin_chg};
	wire stat_rd = rd_fire && rd_idx == GSP_IDX_IRQ_STAT;

	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready = !w_held_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bad_w_r ? GSP_RESP_SLVERR : GSP_RESP_OKAY;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = bad_r_r ? GSP_RESP_SLVERR : GSP_RESP_OKAY;
	assign gpio_out = (alt_sel & alt_out) | (~alt_sel & out_r);
	assign gpio_oe = (alt_sel & alt_oe) | gp_out;
	assign pkt_valid = state_r == GSP_SEND;
	assign pkt_last = idx_r == pkt_len - 4'h1;
	assign pkt_data = pkt_data_r;
	assign irq = |(istat_r & imask_r);

	// Packet byte for a position; snapshot keeps bytes stable while the host drains
	function automatic logic [7:0] pkt_byte(input logic f, input logic [3:0] i);
		logic [7:0] b;
		b = 8'h00;
		if (f) begin
			// states then change flags, low byte first
			case (i)
				4'h0: b = snap_lvl_r[7:0];
				4'h1: b = {6'h00, snap_lvl_r[9:8]};
				4'h2: b = snap_chg_r[7:0];
				4'h3: b = {6'h00, snap_chg_r[9:8]};
				4'h4: b = {4'h0, snap_st_r[6:4], snap_st_r[2]};
				default: b = 8'h00;
			endcase
		end else begin
			// header bytes; value, index, length words
			case (i)
				4'h0: b = GSP_REQ_TYPE;
				4'h1: b = GSP_NOTIFY_SERIAL;
				4'h4: b = GSP_IFACE_NUM;
				4'h6: b = GSP_STD_LEN;
				4'h8: b = {1'b0, snap_st_r};
				default: b = 8'h00;
			endcase
		end
		pkt_byte = b;
	endfunction

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			GSP_IDLE: if (trig_r) state_nxt = GSP_SEND;
			GSP_SEND: if (pkt_end) state_nxt = GSP_IDLE;
			default: state_nxt = GSP_IDLE;
		endcase
	end

	// Bus channels: address and data taken in either order
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			aw_held_r <= 1'b0;
			w_held_r <= 1'b0;
			bvalid_r <= 1'b0;
			bad_w_r <= 1'b0;
			aw_idx_r <= 6'h00;
			wd_r <= 32'h0000_0000;
			ws_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_held_r) begin
				aw_held_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[7:2];
			end
			if (s_axi_wvalid && !w_held_r) begin
				w_held_r <= 1'b1;
				wd_r <= s_axi_wdata;
				ws_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				bvalid_r <= 1'b1;
				bad_w_r <= !wr_ok;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
				aw_held_r <= 1'b0;
				w_held_r <= 1'b0;
			end
		end
	end

	// live pin levels; masked pins still read; upper bits zero
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rvalid_r <= 1'b0;
			bad_r_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			bad_r_r <= 1'b0;
			case (rd_idx)
				GSP_IDX_DIR: rdata_r <= {22'h000000, dir_r};
				GSP_IDX_LEVEL: rdata_r <= {22'h000000, gpio_in};
				GSP_IDX_MASK: rdata_r <= {22'h000000, mask_r};
				GSP_IDX_CTRL: rdata_r <= {30'h00000000, ctrl_r};
				GSP_IDX_IRQ_STAT: rdata_r <= {29'h00000000, istat_r};
				GSP_IDX_IRQ_MASK: rdata_r <= {29'h00000000, imask_r};
				GSP_IDX_SET, GSP_IDX_CLR: rdata_r <= 32'h0000_0000;
				default: begin
					rdata_r <= 32'h0000_0000;
					bad_r_r <= 1'b1;
				end
			endcase
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			dir_r <= 10'h000;
			out_r <= 10'h000;
			mask_r <= GSP_MASK_RST;
			ctrl_r <= 2'h0;
			imask_r <= 3'h0;
		end else if (wr_ok) begin
			case (aw_idx_r)
				GSP_IDX_DIR: dir_r <= lane_merge(dir_r, wd_r, ws_r);
				GSP_IDX_SET: out_r <= out_r | (wbits & gp_out);
				GSP_IDX_CLR: out_r <= out_r & ~(wbits & gp_out);
				GSP_IDX_LEVEL: out_r <= (out_r & ~gp_out) | (lane_merge(out_r, wd_r, ws_r) & gp_out);
				GSP_IDX_MASK: mask_r <= lane_merge(mask_r, wd_r, ws_r);
				GSP_IDX_CTRL: ctrl_r <= ws_r[0] ? wd_r[1:0] : ctrl_r;
				GSP_IDX_IRQ_MASK: imask_r <= ws_r[0] ? wd_r[2:0] : imask_r;
				default: out_r <= out_r;
			endcase
		end
	end

	// Event capture: a new event beats the clear in the same cycle
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			// Track live levels so no false change follows reset
			prev_r <= gpio_in;
			chg_r <= 10'h000;
			brk_prev_r <= uart_break;
			ovr_r <= 1'b0;
			trig_r <= 1'b0;
			istat_r <= 3'h0;
		end else begin
			prev_r <= gpio_in;
			brk_prev_r <= uart_break;
			chg_r <= (pkt_start ? 10'h000 : chg_r) | pin_chg;
			ovr_r <= (pkt_start ? 1'b0 : ovr_r) | uart_overrun;
			trig_r <= (pkt_start ? 1'b0 : trig_r) | chg_trig | brk_trig;
			istat_r <= (stat_rd ? 3'h0 : istat_r) | ev;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_r <= GSP_IDLE;
			idx_r <= 4'h0;
			fmt_r <= 1'b0;
			snap_lvl_r <= 10'h000;
			snap_chg_r <= 10'h000;
			snap_st_r <= 7'h00;
			pkt_data_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			if (pkt_start) begin
				// format fixed for the whole packet
				fmt_r <= ctrl_r[GSP_CTRL_FMT];
				snap_lvl_r <= gpio_in;
				snap_chg_r <= chg_r | pin_chg;
				snap_st_r <= {ovr_r | uart_overrun, uart_parity_err, uart_framing_err, modem_ring, uart_break,
					modem_dsr, modem_cd};
				idx_r <= 4'h0;
			end else if (pkt_hs) begin
				idx_r <= idx_r + 4'h1;
				pkt_data_r <= pkt_byte(fmt_r, idx_r + 4'h1);
			end
			if (state_r == GSP_IDLE && !pkt_start)
				pkt_data_r <= 8'h00;
			else if (state_r == GSP_IDLE)
				pkt_data_r <= ctrl_r[GSP_CTRL_FMT] ? gpio_in[7:0] : GSP_REQ_TYPE;
		end
	end

	chk_clear_drives_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ok && aw_idx_r == GSP_IDX_CLR && wbits[0] && gp_out[0] |=> !out_r[0])
		else $error("clear write left output high");
	chk_clear_zero_keeps: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ok && aw_idx_r == GSP_IDX_CLR |=> (out_r & ~$past(wbits)) == ($past(out_r) & ~$past(wbits)))
		else $error("clear write changed a zero bit");
	chk_clear_spares_others: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ok && aw_idx_r == GSP_IDX_CLR |=> ((out_r ^ $past(out_r)) & ~$past(gp_out)) == 10'h000)
		else $error("clear write touched a non-output pin");
	chk_level_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
		rd_fire && rd_idx == GSP_IDX_LEVEL |=> s_axi_rvalid && s_axi_rdata == {22'h000000, $past(gpio_in)})
		else $error("level read not live pins");
	chk_level_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_ok && aw_idx_r == GSP_IDX_LEVEL && ws_r == 4'hF |=>
		(out_r & $past(gp_out)) == ($past(wd_r[9:0]) & $past(gp_out)))
		else $error("level write did not drive outputs");
	chk_change_starts_pkt: assert property (@(posedge clk_sys) disable iff (!rst_n)
		chg_trig && state_r == GSP_IDLE |-> ##[1:2] pkt_valid)
		else $error("unmasked change gave no packet");
	chk_alt_input_masked: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pin_chg & alt_sel & ~mask_r) != 10'h000 |-> chg_trig)
		else $error("alternate input change ignored");
	chk_break_gated: assert property (@(posedge clk_sys) disable iff (!rst_n)
		brk_edge && !ctrl_r[GSP_CTRL_BRK] && !chg_trig && !trig_r && state_r == GSP_IDLE |=> !trig_r)
		else $error("disabled break raised a packet");
	chk_break_enabled: assert property (@(posedge clk_sys) disable iff (!rst_n)
		brk_edge && ctrl_r[GSP_CTRL_BRK] |=> trig_r)
		else $error("enabled break raised no packet");
	chk_std_header: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_start && !ctrl_r[GSP_CTRL_FMT] |=> pkt_data == 8'hA1)
		else $error("standard packet header wrong");
	chk_std_notify_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_valid && !fmt_r && idx_r == 4'h1 |-> pkt_data == 8'h20)
		else $error("standard notification code wrong");
	chk_std_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_valid && !fmt_r && idx_r == 4'h6 |-> pkt_data == 8'h02)
		else $error("standard length byte wrong");
	chk_std_data_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_valid && !fmt_r && idx_r == 4'h9 |-> pkt_data == 8'h00)
		else $error("standard data high byte nonzero");
	chk_custom_status_top: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_valid && fmt_r && idx_r == 4'h4 |-> pkt_data[7:4] == 4'h0)
		else $error("custom status upper bits nonzero");
	chk_fmt_length: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pkt_end |-> idx_r == (fmt_r ? 4'h4 : 4'h9))
		else $error("packet length does not match format");
	chk_dir_enable: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(gpio_oe & ~alt_sel) == (dir_r & ~alt_sel))
		else $error("direction not applied to pins");
	chk_reserved_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_axi_rvalid |-> s_axi_rdata[31:10] == 22'h000000)
		else $error("reserved bits read nonzero");

	cov_std_packet: cover property (@(posedge clk_sys) disable iff (!rst_n) pkt_end && !fmt_r);
	cov_custom_packet: cover property (@(posedge clk_sys) disable iff (!rst_n) pkt_end && fmt_r);
	cov_break_packet: cover property (@(posedge clk_sys) disable iff (!rst_n) brk_trig ##[1:2] pkt_valid);
	cov_irq_raised: cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(irq));
endmodule

// >>> hw/gsp_pkg.sv
/*
 Constants for the pin state and notification packet block.
 Assumes a 25 MHz system clock and 32-bit AXI4-Lite register access.
*/
// How it works
// - A one written to a low ten bit of output_clear drives that general-purpose output low, a zero leaves it.
// - output_clear leaves alternate-function pins and input pins untouched.
// - Reading pin_level returns the live level of all ten pins.
// - Writing pin_level drives each general-purpose output to the written bit.
// - An input change on an unmasked pin starts a packet; the mask resets to 0x100.
// - Masking covers every input pin, general-purpose or alternate.
// - Masked pins still show their level in reads and in packets.
// - With control bit 1 set a received break starts a packet, otherwise it does not.
// - Control bit 0 picks standard (0) or customized (1) packet layout.
// - The standard packet opens with 8'b10100001 then 8'h20.
// - Then a zero value word, index word 8'h00, length word 16'h0002 and two data bytes.
// - Standard data holds overrun D6, parity D5, framing D4, ring D3, break D2, DSR D1, carrier D0.
// - The overrun bit is set whenever received data was discarded.
// - The customized packet carries pin states in bytes 0-1 and change flags in bytes 2-3.
// - Its byte 4 holds overrun D3, parity D2, framing D1, break D0.
// - A direction bit of zero makes a general-purpose pin an input, one an output.
package gsp_pkg;
	localparam int GSP_NPIN = 10;
	localparam logic [5:0] GSP_IDX_DIR = 6'h0D;
	localparam logic [5:0] GSP_IDX_SET = 6'h0E;
	localparam logic [5:0] GSP_IDX_CLR = 6'h0F;
	localparam logic [5:0] GSP_IDX_LEVEL = 6'h10;
	localparam logic [5:0] GSP_IDX_MASK = 6'h11;
	localparam logic [5:0] GSP_IDX_CTRL = 6'h12;
	localparam logic [5:0] GSP_IDX_IRQ_STAT = 6'h20;
	localparam logic [5:0] GSP_IDX_IRQ_MASK = 6'h21;
	localparam logic [9:0] GSP_MASK_RST = 10'h100;
	localparam int GSP_CTRL_FMT = 0;
	localparam int GSP_CTRL_BRK = 1;
	localparam int GSP_IRQ_CHG = 0;
	localparam int GSP_IRQ_BRK = 1;
	localparam int GSP_IRQ_SENT = 2;
	localparam logic [7:0] GSP_REQ_TYPE = 8'hA1;
	localparam logic [7:0] GSP_NOTIFY_SERIAL = 8'h20;
	localparam logic [7:0] GSP_IFACE_NUM = 8'h00;
	localparam logic [7:0] GSP_STD_LEN = 8'h02;
	localparam logic [3:0] GSP_STD_BYTES = 4'hA;
	localparam logic [3:0] GSP_CUS_BYTES = 4'h5;
	localparam logic [1:0] GSP_RESP_OKAY = 2'h0;
	localparam logic [1:0] GSP_RESP_SLVERR = 2'h2;
	typedef enum logic {GSP_IDLE, GSP_SEND} gsp_state_type;
endpackage

// >>> tb/gsp_host_sink.sv
/*
 Host side of the notification endpoint: takes packet bytes into a log.
 Assumes one byte moves at each edge with pkt_valid and pkt_ready high.
*/
`timescale 1ns/100ps
module gsp_host_sink (
	input wire logic clk_sys,
	input wire logic slow,
	input wire logic [7:0] pkt_data,
	input wire logic pkt_valid,
	input wire logic pkt_last,
	output logic pkt_ready
);
	logic [7:0] buf_r [0:63];
	int n_r = 0;
	int n_pkt = 0;
	logic tog_r = 1'h0;
	// Slow mode stalls every other cycle
	assign pkt_ready = !slow || tog_r;
	always @(posedge clk_sys) begin
		tog_r <= !tog_r;
		if (pkt_valid && pkt_ready) begin
			buf_r[n_r] <= pkt_data;
			n_r <= n_r + 1;
			if (pkt_last)
				n_pkt <= n_pkt + 1;
		end
	end
endmodule

// >>> tb/gsp_tb.sv
/*
 Self-checking bench: register access, pin control and notify packets.
 Assumes the host sink model and the slave's AXI4-Lite handshakes.
*/
`timescale 1ns/100ps
module testbench;
	import gsp_pkg::*;
	logic clk_sys = 1'h0, rst_n = 1'h0, slow = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, r;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rresp_r, bresp_r;
	logic [9:0] gpio_in = 10'h0, alt_sel = 10'h0, alt_out = 10'h0, alt_oe = 10'h0;
	logic [9:0] gpio_out, gpio_oe;
	logic uart_overrun = 1'h0, uart_parity_err = 1'h0, uart_framing_err = 1'h0;
	logic uart_break = 1'h0, modem_ring = 1'h0, modem_dsr = 1'h0, modem_cd = 1'h0;
	logic [7:0] pkt_data;
	logic pkt_valid, pkt_last, pkt_ready, irq;
	int n_errors = 0;
	int checks = 0;
	gsp_gpio_notify u_gsp_gpio_notify (.clk_sys, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .gpio_in, .gpio_out, .gpio_oe, .alt_sel, .alt_out, .alt_oe,
		.uart_overrun, .uart_parity_err, .uart_framing_err, .uart_break, .modem_ring, .modem_dsr,
		.modem_cd, .pkt_data, .pkt_valid, .pkt_last, .pkt_ready, .irq);
	gsp_host_sink u_gsp_host_sink (.clk_sys, .slow, .pkt_data, .pkt_valid, .pkt_last, .pkt_ready);
	initial forever #20 clk_sys = ~clk_sys;
	task automatic close_out();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// Each channel is released at the edge where its own ready is sampled high
	task automatic wr(input logic [5:0] ix, input logic [31:0] d);
		logic aw_left;
		logic w_left;
		@(posedge clk_sys);
		s_axi_awaddr <= {ix, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw_left = 1'h1;
		w_left = 1'h1;
		while (aw_left || w_left) begin
			@(posedge clk_sys);
			if (aw_left && s_axi_awready) begin
				aw_left = 1'h0;
				s_axi_awvalid <= 1'h0;
			end
			if (w_left && s_axi_wready) begin
				w_left = 1'h0;
				s_axi_wvalid <= 1'h0;
			end
		end
		do @(posedge clk_sys); while (!s_axi_bvalid);
		bresp_r = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [5:0] ix, output logic [31:0] d);
		@(posedge clk_sys);
		s_axi_araddr <= {ix, 2'h0};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do @(posedge clk_sys); while (!s_axi_arready);
		s_axi_arvalid <= 1'h0;
		do @(posedge clk_sys); while (!s_axi_rvalid);
		d = s_axi_rdata;
		rresp_r = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask
	task automatic rdchk(input logic [5:0] ix, input logic [31:0] exp);
		logic [31:0] v;
		rd(ix, v);
		chk(v, exp);
	endtask
	task automatic pin(input logic [9:0] v);
		@(posedge clk_sys);
		gpio_in <= v;
	endtask
	// Waits for a whole packet, then compares its bytes, first byte lowest
	task automatic pkt(input int n, input logic [79:0] e);
		int b;
		int p;
		b = u_gsp_host_sink.n_r;
		p = u_gsp_host_sink.n_pkt;
		while (u_gsp_host_sink.n_pkt == p) @(posedge clk_sys);
		chk(u_gsp_host_sink.n_r - b, n);
		for (int i = 0; i < n; i++) chk(u_gsp_host_sink.buf_r[b + i], e[8 * i +: 8]);
	endtask
	task automatic none();
		int p;
		p = u_gsp_host_sink.n_pkt;
		repeat (20) @(posedge clk_sys);
		chk(u_gsp_host_sink.n_pkt, p);
	endtask
	initial begin
		#400000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'h1;
		rdchk(GSP_IDX_MASK, 32'h100);
		rdchk(GSP_IDX_CTRL, 32'h0);
		rdchk(6'h3F, 32'h0);
		chk(rresp_r, GSP_RESP_SLVERR);
		pin(10'h100);
		none();
		wr(GSP_IDX_MASK, 32'hFFFF);
		chk(bresp_r, GSP_RESP_OKAY);
		wr(6'h3F, 32'hFFFF);
		chk(bresp_r, GSP_RESP_SLVERR);
		rdchk(GSP_IDX_MASK, 32'h3FF);
		pin(10'h155);
		none();
		rdchk(GSP_IDX_LEVEL, 32'h155);
		alt_sel <= 10'h200;
		alt_out <= 10'h200;
		alt_oe <= 10'h200;
		wr(GSP_IDX_DIR, 32'h3FF);
		wr(GSP_IDX_LEVEL, 32'h0FF);
		chk(gpio_out, 32'h2FF);
		wr(GSP_IDX_CLR, 32'h20F);
		chk(gpio_out, 32'h2F0);
		wr(GSP_IDX_DIR, 32'h00F);
		chk(gpio_oe, 32'h20F);
		wr(GSP_IDX_CLR, 32'h0F0);
		wr(GSP_IDX_DIR, 32'h3FF);
		chk(gpio_out, 32'h2F0);
		wr(GSP_IDX_SET, 32'h30F);
		chk(gpio_out, 32'h3FF);
		alt_sel <= 10'h001;
		alt_oe <= 10'h0;
		wr(GSP_IDX_DIR, 32'h0);
		wr(GSP_IDX_MASK, 32'h3FE);
		modem_cd <= 1'h1;
		modem_ring <= 1'h1;
		uart_overrun <= 1'h1;
		pin(10'h154);
		uart_overrun <= 1'h0;
		pkt(10, 80'h00_49_00_02_00_00_00_00_20_A1);
		uart_parity_err <= 1'h1;
		uart_framing_err <= 1'h1;
		slow <= 1'h1;
		wr(GSP_IDX_CTRL, 32'h1);
		pin(10'h155);
		pkt(5, 80'h06_00_01_01_55);
		slow <= 1'h0;
		uart_break <= 1'h1;
		none();
		uart_break <= 1'h0;
		wr(GSP_IDX_IRQ_MASK, 32'h4);
		wr(GSP_IDX_CTRL, 32'h3);
		rd(GSP_IDX_IRQ_STAT, r);
		chk(r, 32'h7);
		@(posedge clk_sys);
		chk(irq, 32'h0);
		uart_break <= 1'h1;
		pkt(5, 80'h07_00_00_01_55);
		@(posedge clk_sys);
		chk(irq, 32'h1);
		rd(GSP_IDX_IRQ_STAT, r);
		chk(r, 32'h6);
		@(posedge clk_sys);
		chk(irq, 32'h0);
		close_out();
	end
endmodule
